// *** logic/scrd_pkg.sv ***
`default_nettype none
package scrd_pkg;
   // Read op-codes for message records
   localparam logic [7:0] OP_TMP_TT  = 8'h42;
   localparam logic [7:0] OP_TMP_NT  = 8'h44;
   localparam logic [7:0] OP_FIFO_TT = 8'h46;
   localparam logic [7:0] OP_FIFO_NT = 8'h48;
   localparam logic [7:0] OP_DAT_TT  = 8'h4A;
   localparam logic [7:0] OP_DAT_NT  = 8'h4C;
   // Index i holds the op-code for filter or mask i
   localparam logic [7:0][7:0] OP_FILT = {8'hB2, 8'hAE, 8'hAC, 8'hAA,
                                          8'hA8, 8'hA6, 8'hA4, 8'hA2};
   localparam logic [7:0][7:0] OP_MASK = {8'hC4, 8'hC2, 8'hBE, 8'hBC,
                                          8'hBA, 8'hB8, 8'hB6, 8'hB4};
   // Index matches the byte lane of scrd_regs_t cast to [9:0][7:0]
   localparam logic [9:0][7:0] OP_REG = {8'hD2, 8'hD4, 8'hD6, 8'hD8, 8'hDA,
                                         8'hDC, 8'hDE, 8'hE2, 8'hE4, 8'hE6};
   // Data bytes returned per instruction
   localparam logic [4:0] LEN_TMP_TT  = 5'h0F;
   localparam logic [4:0] LEN_TMP_NT  = 5'h0D;
   localparam logic [4:0] LEN_FIFO_TT = 5'h10;
   localparam logic [4:0] LEN_FIFO_NT = 5'h0E;
   localparam logic [4:0] LEN_DAT_TT  = 5'h0B;
   localparam logic [4:0] LEN_DAT_NT  = 5'h09;
   localparam logic [4:0] LEN_ID      = 5'h06;
   localparam logic [4:0] LEN_REG     = 5'h01;
   localparam logic [7:0] CMD_RST     = 8'h00;

   typedef enum logic [3:0] {
      RD_NONE = 4'h0, RD_TMP_TT = 4'h1, RD_TMP_NT = 4'h2, RD_FIFO_TT = 4'h3,
      RD_FIFO_NT = 4'h4, RD_DAT_TT = 4'h5, RD_DAT_NT = 4'h6, RD_FILT = 4'h7,
      RD_MASK = 4'h8, RD_REG = 4'h9
   } scrd_kind_t;

   typedef enum logic [1:0] {
      ST_CMD = 2'h0, ST_SEND = 2'h1, ST_DONE = 2'h2
   } scrd_state_t;

   typedef struct packed {
      scrd_kind_t kind;
      logic [3:0] sel;
      logic [4:0] len;
   } scrd_dec_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic mosi;
   } scrd_pins_t;

   localparam scrd_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b0};

   typedef struct packed {
      logic data;
      logic oe;
   } scrd_so_t;

   typedef struct packed {
      logic [7:0] control_reg_first;
      logic [7:0] control_reg_second;
      logic [7:0] bit_timing_first;
      logic [7:0] bit_timing_second;
      logic [7:0] message_status_reg;
      logic [7:0] error_reg;
      logic [7:0] interrupt_flag_reg;
      logic [7:0] status_flag_reg;
      logic [7:0] interrupt_enable_reg;
      logic [7:0] status_flag_enable_reg;
   } scrd_regs_t;

   // Record byte n (1..16) sits at index n-1
   typedef logic [15:0][7:0] scrd_rec_t;
   // Eight identifiers of six bytes, byte 0 sent first
   typedef logic [7:0][5:0][7:0] scrd_ids_t;
endpackage : scrd_pkg
`default_nettype wire

// *** logic/scrd_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
// Contract
// R1: Each transaction opens with an 8-bit command byte right after select.
// R2: Host ignores what it receives while sending the command byte.
// R3: Single-register access is command, one data byte, then select released.
// R4: Device supplies consecutive bytes up to the instruction's byte count.
// R5: Host sends no undefined op-code; such reads return nothing useful.
// R6: One command per select assertion; re-select before the next command.
// R7: 0x42 returns 15 bytes, temporary record bytes 2 to 16.
// R8: 0x44 returns 13 bytes, temporary record bytes 4 to 16.
// R9: 0x46 returns 16 bytes, FIFO record bytes 1 to 16.
// R10: 0x48 returns 14 bytes, FIFO record byte 1 then 4 to 16.
// R11: 0x4A returns 11 bytes, FIFO record bytes 1 to 3, 9 to 16.
// R12: 0x4C returns 9 bytes, FIFO record byte 1 then 9 to 16.
// R13: Filter 0 to 7 identifiers read by 0xA2..0xB2, six bytes each.
// R14: Mask 0 to 7 identifiers read by 0xB4..0xC4, six bytes each.
// R15: 0xD2 and 0xD4 return first and second control registers.
// R16: 0xD6 and 0xD8 return first and second bit timing registers.
// R17: 0xDA returns message status, 0xDC returns error register.
// R18: 0xDE returns interrupt flags, 0xE2 returns status flags.
// R19: 0xE4 returns interrupt enables, 0xE6 returns status flag enables.
// R20: Clock idles low, sample on rising edge, change on falling edge.
// R21: Bytes move most significant bit first over eight clocks.
// R22: Select released mid-byte discards the byte and restarts the interface.
// R23: Output released except while sending read data; input ignored meanwhile.
module scrd_decoder (
   input  wire logic                 i_clk,
   input  wire logic                 i_rst_n,
   input  wire scrd_pkg::scrd_pins_t i_pins,
   input  wire scrd_pkg::scrd_rec_t  i_tmp_rec,
   input  wire scrd_pkg::scrd_rec_t  i_fifo_rec,
   input  wire scrd_pkg::scrd_ids_t  i_filt,
   input  wire scrd_pkg::scrd_ids_t  i_mask,
   input  wire scrd_pkg::scrd_regs_t i_regs,
   output var  scrd_pkg::scrd_so_t   o_so,
   output var  logic [7:0]           o_cmd,
   output var  logic                 o_cmd_vld,
   output var  logic                 o_fifo_pop
);
   scrd_pkg::scrd_pins_t  s1_r;
   scrd_pkg::scrd_pins_t  s2_r;
   logic                  sck_d_r;
   logic                  sck_rise;
   logic                  sck_fall;
   logic                  cs_on;
   scrd_pkg::scrd_state_t st_r;
   logic [6:0]            rx_r;
   logic [2:0]            rx_cnt_r;
   logic [2:0]            tx_cnt_r;
   logic [6:0]            tx_sh_r;
   logic [4:0]            idx_r;
   scrd_pkg::scrd_kind_t  kind_r;
   logic [3:0]            sel_r;
   logic [4:0]            len_r;
   scrd_pkg::scrd_dec_t   dec;
   logic [9:0][7:0]       reg_bytes;
   logic [3:0]            ri;
   logic [7:0]            cur_byte;
   logic                  load_byte;
   logic                  end_tx;
   logic                  cmd_done;
   logic                  fifo_kind;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   function automatic scrd_pkg::scrd_dec_t decode(input logic [7:0] op);
      decode = '{kind: scrd_pkg::RD_NONE, sel: 4'h0, len: 5'h00};
      case (op)
         scrd_pkg::OP_TMP_TT:  decode = '{scrd_pkg::RD_TMP_TT, 4'h0, scrd_pkg::LEN_TMP_TT};
         scrd_pkg::OP_TMP_NT:  decode = '{scrd_pkg::RD_TMP_NT, 4'h0, scrd_pkg::LEN_TMP_NT};
         scrd_pkg::OP_FIFO_TT: decode = '{scrd_pkg::RD_FIFO_TT, 4'h0, scrd_pkg::LEN_FIFO_TT};
         scrd_pkg::OP_FIFO_NT: decode = '{scrd_pkg::RD_FIFO_NT, 4'h0, scrd_pkg::LEN_FIFO_NT};
         scrd_pkg::OP_DAT_TT:  decode = '{scrd_pkg::RD_DAT_TT, 4'h0, scrd_pkg::LEN_DAT_TT};
         scrd_pkg::OP_DAT_NT:  decode = '{scrd_pkg::RD_DAT_NT, 4'h0, scrd_pkg::LEN_DAT_NT};
         default: ;
      endcase
      for (int i = 0; i < 8; i++) begin
         if (op == scrd_pkg::OP_FILT[i]) begin
            decode = '{scrd_pkg::RD_FILT, 4'(i), scrd_pkg::LEN_ID};
         end
         if (op == scrd_pkg::OP_MASK[i]) begin
            decode = '{scrd_pkg::RD_MASK, 4'(i), scrd_pkg::LEN_ID};
         end
      end
      for (int i = 0; i < 10; i++) begin
         if (op == scrd_pkg::OP_REG[i]) begin
            decode = '{scrd_pkg::RD_REG, 4'(i), scrd_pkg::LEN_REG};
         end
      end
   endfunction : decode

   // Pin synchroniser; the second stage feeds all logic
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_r    <= scrd_pkg::PINS_IDLE;
         s2_r    <= scrd_pkg::PINS_IDLE;
         sck_d_r <= 1'b0;
      end else begin
         s1_r    <= i_pins;
         s2_r    <= s1_r;
         sck_d_r <= s2_r.sck;
      end
   end

   // R20 mode-0 edge detect
   assign sck_rise = s2_r.sck & ~sck_d_r;
   assign sck_fall = ~s2_r.sck & sck_d_r;
   assign cs_on    = ~s2_r.cs_n;
   assign cmd_done = cs_on && (st_r == scrd_pkg::ST_CMD) && sck_rise && (rx_cnt_r == 3'h7);
   assign dec      = decode({rx_r, s2_r.mosi});
   assign load_byte = cs_on && (st_r == scrd_pkg::ST_SEND) && sck_fall
                      && (tx_cnt_r == 3'h0) && (idx_r < len_r);
   assign end_tx   = cs_on && (st_r == scrd_pkg::ST_SEND) && sck_fall
                      && (tx_cnt_r == 3'h0) && (idx_r >= len_r);
   assign fifo_kind = (kind_r == scrd_pkg::RD_FIFO_TT) || (kind_r == scrd_pkg::RD_FIFO_NT)
                      || (kind_r == scrd_pkg::RD_DAT_TT) || (kind_r == scrd_pkg::RD_DAT_NT);
   assign reg_bytes = i_regs;

   // R7 record byte map
   always_comb begin
      ri = idx_r[3:0];
      unique case (kind_r)
         scrd_pkg::RD_TMP_TT:  ri = idx_r[3:0] + 4'h1;
         // R8 skip time tag
         scrd_pkg::RD_TMP_NT:  ri = idx_r[3:0] + 4'h3;
         // R10 skip time tag
         scrd_pkg::RD_FIFO_NT: ri = (idx_r == 5'h00) ? 4'h0 : idx_r[3:0] + 4'h2;
         // R11 data only
         scrd_pkg::RD_DAT_TT:  ri = (idx_r < 5'h03) ? idx_r[3:0] : idx_r[3:0] + 4'h5;
         // R12 data only
         scrd_pkg::RD_DAT_NT:  ri = (idx_r == 5'h00) ? 4'h0 : idx_r[3:0] + 4'h7;
         default:              ri = idx_r[3:0];
      endcase
   end

   always_comb begin
      cur_byte = 8'h00;
      unique case (kind_r)
         scrd_pkg::RD_TMP_TT, scrd_pkg::RD_TMP_NT: cur_byte = i_tmp_rec[ri];
         // R9 to R12 FIFO record bytes
         scrd_pkg::RD_FIFO_TT, scrd_pkg::RD_FIFO_NT,
         scrd_pkg::RD_DAT_TT, scrd_pkg::RD_DAT_NT: cur_byte = i_fifo_rec[ri];
         // R13 filter identifiers
         scrd_pkg::RD_FILT: begin
            if (idx_r < scrd_pkg::LEN_ID) cur_byte = i_filt[sel_r[2:0]][idx_r[2:0]];
         end
         // R14 mask identifiers
         scrd_pkg::RD_MASK: begin
            if (idx_r < scrd_pkg::LEN_ID) cur_byte = i_mask[sel_r[2:0]][idx_r[2:0]];
         end
         // R15 R16 R17 R18 R19 register bytes
         scrd_pkg::RD_REG: begin
            if (sel_r < 4'hA) cur_byte = reg_bytes[sel_r];
         end
         default: cur_byte = 8'h00;
      endcase
   end

   // Transaction engine
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st_r     <= scrd_pkg::ST_CMD;
         rx_r     <= 7'h00;
         rx_cnt_r <= 3'h0;
         tx_cnt_r <= 3'h0;
         tx_sh_r  <= 7'h00;
         idx_r    <= 5'h00;
         kind_r   <= scrd_pkg::RD_NONE;
         sel_r    <= 4'h0;
         len_r    <= 5'h00;
      end else if (!cs_on) begin
         // R22 restart on deselect
         st_r     <= scrd_pkg::ST_CMD;
         rx_cnt_r <= 3'h0;
         tx_cnt_r <= 3'h0;
         idx_r    <= 5'h00;
      end else begin
         unique case (st_r)
            scrd_pkg::ST_CMD: begin
               // R1 command shift
               if (sck_rise) begin
                  rx_r     <= {rx_r[5:0], s2_r.mosi};
                  rx_cnt_r <= rx_cnt_r + 3'h1;
               end
               if (cmd_done) begin
                  kind_r <= dec.kind;
                  sel_r  <= dec.sel;
                  len_r  <= dec.len;
                  // R5 undefined op-code sends nothing
                  st_r   <= (dec.kind == scrd_pkg::RD_NONE) ? scrd_pkg::ST_DONE
                                                            : scrd_pkg::ST_SEND;
               end
            end
            scrd_pkg::ST_SEND: begin
               // R23 input ignored while sending
               if (sck_fall) begin
                  tx_cnt_r <= tx_cnt_r + 3'h1;
                  tx_sh_r  <= {tx_sh_r[5:0], 1'b0};
               end
               // R4 byte count limit
               if (load_byte) begin
                  tx_sh_r <= cur_byte[6:0];
                  idx_r   <= idx_r + 5'h01;
               end
               if (end_tx) begin
                  st_r <= scrd_pkg::ST_DONE;
               end
            end
            // R6 one command per select
            scrd_pkg::ST_DONE: st_r <= scrd_pkg::ST_DONE;
            default: st_r <= scrd_pkg::ST_CMD;
         endcase
      end
   end

   // Serial output driver
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_so <= '{data: 1'b0, oe: 1'b0};
      end else if (!cs_on || end_tx) begin
         // R23 release output
         o_so.oe <= 1'b0;
      end else if (load_byte) begin
         // R21 MSB first
         o_so <= '{data: cur_byte[7], oe: 1'b1};
      end else if (st_r == scrd_pkg::ST_SEND && sck_fall) begin
         o_so.data <= tx_sh_r[6];
      end
   end

   // Command report and FIFO advance
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cmd      <= scrd_pkg::CMD_RST;
         o_cmd_vld  <= 1'b0;
         o_fifo_pop <= 1'b0;
      end else begin
         o_cmd_vld  <= cmd_done;
         if (cmd_done) o_cmd <= {rx_r, s2_r.mosi};
         o_fifo_pop <= !cs_on && (st_r != scrd_pkg::ST_CMD) && fifo_kind
                       && (idx_r != 5'h00);
      end
   end

   cmd_edge_a: assert property (o_cmd_vld |-> $past(st_r) == scrd_pkg::ST_CMD // R1
      && $past(sck_rise) && $past(rx_cnt_r) == 3'h7) else $error("command not on 8th edge");
   byte_cap_a: assert property (o_so.oe |-> idx_r != 5'h00 && idx_r <= len_r) // R4
      else $error("byte past instruction count");
   one_cmd_a: assert property ((st_r != scrd_pkg::ST_CMD) ##1 cs_on // R6
      |-> st_r != scrd_pkg::ST_CMD) else $error("second command in one select");
   tmp_len_a: assert property (o_cmd_vld && o_cmd == scrd_pkg::OP_TMP_TT // R7
      |-> kind_r == scrd_pkg::RD_TMP_TT && len_r == 5'h0F) else $error("0x42 length");
   fifo_len_a: assert property (o_cmd_vld && o_cmd == scrd_pkg::OP_FIFO_TT // R9
      |-> len_r == 5'h10) else $error("0x46 length");
   dat_len_a: assert property (o_cmd_vld && o_cmd == scrd_pkg::OP_DAT_NT // R12
      |-> len_r == 5'h09) else $error("0x4C length");
   filt_map_a: assert property (o_cmd_vld && kind_r == scrd_pkg::RD_FILT // R13
      |-> o_cmd == scrd_pkg::OP_FILT[sel_r[2:0]] && len_r == 5'h06) else $error("filter map");
   reg_map_a: assert property (o_cmd_vld && kind_r == scrd_pkg::RD_REG // R15
      |-> o_cmd == scrd_pkg::OP_REG[sel_r] && len_r == 5'h01) else $error("register map");
   edge_mode_a: assert property ($changed(o_so.data) |-> $past(sck_fall)) // R20
      else $error("output changed off falling edge");
   msb_first_a: assert property (load_byte |=> o_so.data == $past(cur_byte[7])) // R21
      else $error("first bit not MSB");
   cs_abort_a: assert property (!cs_on |=> st_r == scrd_pkg::ST_CMD // R22
      && rx_cnt_r == 3'h0 && !o_so.oe) else $error("deselect did not restart");
   quiet_cmd_a: assert property (st_r != scrd_pkg::ST_SEND |-> !o_so.oe) // R23
      else $error("output driven outside send");
   tmp_nt_len_a: assert property (o_cmd_vld && o_cmd == scrd_pkg::OP_TMP_NT // R8
      |-> kind_r == scrd_pkg::RD_TMP_NT && len_r == 5'h0D) else $error("0x44 length");
   fifo_nt_len_a: assert property (o_cmd_vld && o_cmd == scrd_pkg::OP_FIFO_NT // R10
      |-> len_r == 5'h0E) else $error("0x48 length");
   dat_tt_len_a: assert property (o_cmd_vld && o_cmd == scrd_pkg::OP_DAT_TT // R11
      |-> len_r == 5'h0B) else $error("0x4A length");
   mask_map_a: assert property (o_cmd_vld && kind_r == scrd_pkg::RD_MASK // R14
      |-> o_cmd == scrd_pkg::OP_MASK[sel_r[2:0]] && len_r == 5'h06) else $error("mask map");
   bit_time_a: assert property (o_cmd_vld && o_cmd == 8'hD6 // R16
      |-> kind_r == scrd_pkg::RD_REG && sel_r == 4'h7) else $error("bit timing lane");
   msg_err_a: assert property (o_cmd_vld && o_cmd == 8'hDC // R17
      |-> kind_r == scrd_pkg::RD_REG && sel_r == 4'h4) else $error("error register lane");
   flag_reg_a: assert property (o_cmd_vld && o_cmd == 8'hDE // R18
      |-> kind_r == scrd_pkg::RD_REG && sel_r == 4'h3) else $error("interrupt flag lane");
   enable_reg_a: assert property (o_cmd_vld && o_cmd == 8'hE6 // R19
      |-> kind_r == scrd_pkg::RD_REG && sel_r == 4'h0) else $error("flag enable lane");

   fifo_read_c: cover property (o_fifo_pop && len_r == 5'h10);
   mask_read_c: cover property (o_cmd_vld && kind_r == scrd_pkg::RD_MASK);
   reg_read_c: cover property (o_cmd_vld && kind_r == scrd_pkg::RD_REG);
   bad_op_c: cover property (o_cmd_vld && kind_r == scrd_pkg::RD_NONE);
   abort_c: cover property (!cs_on && st_r == scrd_pkg::ST_CMD && rx_cnt_r != 3'h0);
endmodule : scrd_decoder
`default_nettype wire

// *** bench/scrd_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module scrd_host_model (
   input  wire logic                 i_clk,
   input  wire scrd_pkg::scrd_so_t   i_so,
   output var  scrd_pkg::scrd_pins_t o_pins
);
   initial o_pins <= scrd_pkg::PINS_IDLE;

   task automatic half();
      repeat (8) @(posedge i_clk);
   endtask : half

   // change on fall, sample on rise
   task automatic bit_x(input logic b, output logic d, output logic e);
      o_pins.mosi <= b;
      half();
      o_pins.sck <= 1'b1;
      // Released line reads as the inverse of the last bit
      d = i_so.oe ? i_so.data : ~i_so.data;
      e = i_so.oe;
      half();
      o_pins.sck <= 1'b0;
   endtask : bit_x

   task automatic xfer(input logic [7:0] cmd, input int nb, input int cut,
                       output logic [16:0][7:0] rx, output logic [16:0] oa,
                       output logic [16:0] oo);
      logic d;
      logic e;
      rx = '0;
      oa = '1;
      oo = '0;
      o_pins.cs_n <= 1'b0;
      half();
      for (int i = 7; i >= 8 - cut; i--) begin
         bit_x(cmd[i], d, e);
      end
      // consecutive bytes, filler on the data input
      for (int b = 0; b < nb; b++) begin
         for (int i = 7; i >= 0; i--) begin
            bit_x(i[0], d, e);
            rx[b][i] = d;
            oa[b] = oa[b] & e;
            oo[b] = oo[b] | e;
         end
      end
      half();
      o_pins.cs_n <= 1'b1;
      half();
   endtask : xfer
endmodule : scrd_host_model
`default_nettype wire

// *** bench/spi_command_read_decoder_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module spi_command_read_decoder_tb;
   logic                 i_clk;
   logic                 i_rst_n;
   scrd_pkg::scrd_pins_t pins;
   scrd_pkg::scrd_rec_t  tmp_rec;
   scrd_pkg::scrd_rec_t  fifo_rec;
   scrd_pkg::scrd_ids_t  filt;
   scrd_pkg::scrd_ids_t  mask;
   scrd_pkg::scrd_regs_t regs;
   scrd_pkg::scrd_so_t   so;
   logic [7:0]           cmd;
   logic                 cmd_vld;
   logic                 fifo_pop;
   logic [16:0][7:0]     rx;
   logic [16:0]          oa;
   logic [16:0]          oo;
   int                   fails = 0;
   int                   samples_checked = 0;
   int                   n_vld = 0;
   int                   n_pop = 0;

   scrd_decoder scrd_decoder_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pins(pins),
      .i_tmp_rec(tmp_rec), .i_fifo_rec(fifo_rec), .i_filt(filt), .i_mask(mask),
      .i_regs(regs), .o_so(so), .o_cmd(cmd), .o_cmd_vld(cmd_vld), .o_fifo_pop(fifo_pop));
   scrd_host_model scrd_host_model_inst (.i_clk(i_clk), .i_so(so), .o_pins(pins));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      n_vld <= n_vld + int'(cmd_vld === 1'b1);
      n_pop <= n_pop + int'(fifo_pop === 1'b1);
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch at %0t: seen 0x%0h expected 0x%0h", $time, seen, exp);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   task automatic rd(input logic [7:0] op, input int nb);
      int v;
      v = n_vld;
      scrd_host_model_inst.xfer(op, nb, 8, rx, oa, oo);
      check(16'(n_vld - v), 16'h0001);
      check(16'(cmd), 16'(op));
   endtask : rd

   task automatic t_regs();
      logic [9:0][7:0] r;
      r = regs;
      for (int k = 0; k < 10; k++) begin
         rd(scrd_pkg::OP_REG[k], 2);
         check(16'(rx[0]), 16'(r[k]));
         check(16'({oa[0], oo[1]}), 16'h0002);
      end
   endtask : t_regs

   task automatic t_recs();
      logic [7:0] ops [6] = '{8'h42, 8'h44, 8'h46, 8'h48, 8'h4A, 8'h4C};
      int len [6] = '{15, 13, 16, 14, 11, 9};
      int n;
      int p;
      for (int k = 0; k < 6; k++) begin
         p = n_pop;
         rd(ops[k], len[k] + 1);
         for (int j = 0; j < len[k]; j++) begin
            n = k == 0 ? j + 2 : k == 1 ? j + 4 : k == 2 ? j + 1 : j == 0 ? 1 :
                k == 3 ? j + 3 : k == 5 ? j + 8 : j < 3 ? j + 1 : j + 6;
            check(16'(rx[j]), 16'(k < 2 ? tmp_rec[n-1] : fifo_rec[n-1]));
         end
         check(16'({oa[len[k]-1], oo[len[k]]}), 16'h0002);
         check(16'(n_pop - p), 16'(k >= 2));
      end
   endtask : t_recs

   task automatic t_ids();
      for (int f = 0; f < 16; f++) begin
         rd(f < 8 ? scrd_pkg::OP_FILT[f[2:0]] : scrd_pkg::OP_MASK[f[2:0]], 7);
         for (int b = 0; b < 6; b++) begin
            check(16'(rx[b]), 16'(f < 8 ? filt[f[2:0]][b] : mask[f[2:0]][b]));
         end
         check(16'({oa[5], oo[6]}), 16'h0002);
      end
   endtask : t_ids

   task automatic t_bad();
      logic [7:0] ops [4] = '{8'h4E, 8'h12, 8'h56, 8'hF0};
      for (int k = 0; k < 4; k++) begin
         rd(ops[k], 2);
         check(16'({oo[1], oo[0]}), 16'h0000);
      end
   endtask : t_bad

   task automatic t_abort();
      int v;
      v = n_vld;
      scrd_host_model_inst.xfer(8'hD2, 0, 5, rx, oa, oo);
      check(16'(n_vld - v), 16'h0000);
      rd(8'hD4, 1);
      check(16'(rx[0]), 16'(regs.control_reg_second));
   endtask : t_abort

   initial begin
      i_rst_n <= 1'b0;
      regs <= 80'hC1C2_C3C4_C5C6_C7C8_C9CA;
      for (int i = 0; i < 16; i++) begin
         tmp_rec[i] <= 8'(8'h20 + i);
         fifo_rec[i] <= 8'(8'h60 + i);
      end
      for (int f = 0; f < 8; f++) begin
         for (int k = 0; k < 6; k++) begin
            filt[f][k] <= 8'(8'h40 + f * 8 + k);
            mask[f][k] <= 8'(8'h80 + f * 8 + k);
         end
      end
      repeat (5) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      check(16'(so.oe), 16'h0000);
      t_regs();
      t_recs();
      t_ids();
      t_bad();
      t_abort();
      summarize();
   end

   initial begin
      repeat (60000) @(posedge i_clk);
      fails++;
      summarize();
   end
endmodule : spi_command_read_decoder_tb
`default_nettype wire
